// *** verilog/hpc_pkg.sv ***
/*
 * constants, register map and field layout of the hibernation power controller.
 * assumes an axi4-lite register bus with 32-bit data and a single 20 mhz clock.
 */
`default_nettype none
package hpc_pkg;
    // register byte offsets
    localparam logic [7:0] HPC_CTL = 8'h00;      // control
    localparam logic [7:0] HPC_RTC = 8'h04;      // counter seconds
    localparam logic [7:0] HPC_MATCH = 8'h08;    // seconds match
    localparam logic [7:0] HPC_TRIM = 8'h0c;     // trim
    localparam logic [7:0] HPC_SS = 8'h10;       // subseconds
    localparam logic [7:0] HPC_SSMATCH = 8'h14;  // subseconds match
    localparam logic [7:0] HPC_CAL = 8'h18;      // calendar value
    localparam logic [7:0] HPC_CALM = 8'h1c;     // calendar match
    localparam logic [7:0] HPC_WAKE = 8'h20;     // wake enables
    localparam logic [7:0] HPC_IM = 8'h24;       // interrupt enables
    localparam logic [7:0] HPC_RIS = 8'h28;      // raw status, write one clears
    localparam logic [7:0] HPC_TPCTL = 8'h2c;    // tamper control
    localparam logic [7:0] HPC_TPSTAT = 8'h30;   // tamper status
    localparam logic [7:0] HPC_TPLOG = 8'h34;    // tamper log counter stamp
    localparam logic [7:0] HPC_TPEVT = 8'h38;    // tamper log event bits
    localparam logic [7:0] HPC_MEM = 8'h40;      // battery memory base
    // control bit positions
    localparam int CTL_EN = 0;       // module enable
    localparam int CTL_RUN = 1;      // counter run
    localparam int CTL_CAL = 2;      // calendar mode
    localparam int CTL_HIB = 3;      // hibernate request
    localparam int CTL_BATEN = 4;    // abort on low battery
    localparam int CTL_BATCHK = 5;   // forced battery check
    localparam int CTL_OSCREC = 6;   // oscillator recovery
    localparam int CTL_ACTIVE = 7;   // already active (read)
    // interrupt / wake bit positions
    localparam int EV_MATCH = 0;
    localparam int EV_LOWBAT = 1;
    localparam int EV_WAKEPIN = 2;
    localparam int EV_GPIO = 3;
    localparam int EV_RSTPIN = 4;
    localparam int EV_TAMPER = 5;
    localparam int EV_W = 6;
    // sizes and timing
    localparam int SS_W = 15;
    localparam int MEM_N = 16;
    localparam int TP_N = 4;
    localparam int LOG_N = 4;
    localparam logic [SS_W-1:0] SS_TOP = 15'h7fff;
    localparam int TICK_NS = 30518;               // 32768 hz tick period in ns
    localparam int CLK_NS = 50;
    localparam int TICK_CYC = TICK_NS / CLK_NS;   // untrimmed period, TICK_CYC + 1 cycles, rounds up
    localparam int BATCHK_US = 100;               // battery check duration
    localparam int BATCHK_CYC = (BATCHK_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] TRIM_RST = 16'h7fff;  // neutral trim value
    localparam logic [7:0] CAL_WILD = 8'hff;      // wildcard match field
endpackage
`default_nettype wire

// *** verilog/hpc_top.sv ***
/*
 * hibernation power controller: counter with subseconds, match, trim and
 * calendar, battery memory, tamper detect and log, wake sources, battery check.
 * assumes synchronous pins and axi4-lite master at 20 mhz; one access at a time.
 */
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module hpc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic [hpc_pkg::TP_N-1:0] tamper_in,
    input wire logic ext_osc_ok,
    input wire logic wake_pin,
    input wire logic gpio_wake,
    input wire logic rst_pin,
    input wire logic bat_low_in,
    input wire logic por_warm,
    output logic tamper_evt,
    output logic proc_power_off,
    output logic low_battery_interrupt_flag,
    output logic wake_out,
    output logic osc_recover
);
    import hpc_pkg::*;

    // busy phases of the battery check
    typedef enum logic [1:0] {BC_IDLE, BC_RUN, BC_DONE} hpc_bc_t;

    // byte-lane merge, used by every writable register except the wake and interrupt enables, the status and log clears and the log select
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // calendar field compare honouring the wildcard
    function automatic logic fmatch(input logic [7:0] v, input logic [7:0] m);
        return (m == CAL_WILD) || (v == m);
    endfunction

    logic [31:0] ctl_q;                 // control
    logic [31:0] rtc_q, match_q;        // seconds and its match
    logic [15:0] trim_q;                // trim reload
    logic [SS_W-1:0] ss_q, ssm_q;       // subseconds and match
    logic [31:0] cal_q, calm_q;         // calendar sec/min/hour/day bytes
    logic [EV_W-1:0] wake_q, im_q, ris_q;
    logic [31:0] tpctl_q;               // [0] enable [4:1] inputs [5] osc [6] clr mem [7] part [8] wake
    logic [31:0] mem_q [MEM_N];         // battery-backed words
    logic [31:0] log_rtc_q [LOG_N];     // tamper stamps
    logic [TP_N:0] log_evt_q [LOG_N];   // tamper causes
    logic [2:0] log_cnt_q;              // entries held
    logic [1:0] log_rd_q;               // entry shown by read port
    logic [TP_N-1:0] tin_q;             // last tamper input level
    logic osc_q;                        // last oscillator level
    logic [16:0] tick_q;                // prescaler
    logic [31:0] bc_cnt_q;              // battery check timer
    hpc_bc_t bc_q;
    logic hib_pend_q;                   // request held off behind check
    logic active_q, caught_q;
    logic wpin_q, gpin_q, rpin_q, match_d1_q;

    // bus handshake state
    logic aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    wire en = ctl_q[CTL_EN];
    wire wr_go = aw_q && w_q && !s_bvalid;
    wire rd_go = s_arvalid && s_arready;
    wire [3:0] widx = awa_q[5:2];
    wire [3:0] ridx = s_araddr[5:2];
    wire wmem = wr_go && awa_q[7:6] == 2'b01;
    wire wr_hit = wr_go && (awa_q == HPC_CTL || en);
    wire wsel_ctl = wr_go && awa_q == HPC_CTL;
    wire [31:0] trim_m = merge({16'h0000, trim_q}, wd_q, ws_q);         // trim after byte lanes
    wire [31:0] ssm_m = merge({17'h00000, ssm_q}, wd_q, ws_q);          // sub match after lanes

    // counter tick: trim reload shortens the second when trim is 1 to TICK_CYC below neutral; further below, the prescaler wraps and stretches it
    wire ss_tick = en && ctl_q[CTL_RUN] && tick_q == 17'(TICK_CYC);
    wire sec_tick = ss_tick && ss_q == SS_TOP;
    wire [15:0] trim_off = trim_q - TRIM_RST;
    wire rtc_match = rtc_q == match_q && ss_q == ssm_q;
    wire cal_match = fmatch(cal_q[7:0], calm_q[7:0]) && fmatch(cal_q[15:8], calm_q[15:8])
        && fmatch(cal_q[23:16], calm_q[23:16]) && fmatch(cal_q[31:24], calm_q[31:24]);
    wire any_match = ctl_q[CTL_CAL] ? cal_match : rtc_match;
    wire match_ev = en && any_match && !match_d1_q;
    wire [TP_N-1:0] tin_edge = (tamper_in ^ tin_q) & tpctl_q[4:1];
    wire osc_fail = tpctl_q[5] && osc_q && !ext_osc_ok;
    wire tp_ev = en && tpctl_q[0] && (|tin_edge || osc_fail);
    logic [EV_W-1:0] ev;
    assign ev[EV_MATCH] = match_ev;
    assign ev[EV_LOWBAT] = bc_q == BC_DONE && bat_low_in;
    assign ev[EV_WAKEPIN] = en && wake_pin && !wpin_q;
    assign ev[EV_GPIO] = en && gpio_wake && !gpin_q;
    assign ev[EV_RSTPIN] = en && rst_pin && !rpin_q;
    assign ev[EV_TAMPER] = tp_ev;
    wire wake_ev = |(ev & wake_q) || (tp_ev && tpctl_q[8]);
    wire clr_ris = wr_hit && awa_q == HPC_RIS;
    wire [EV_W-1:0] ris_clr = clr_ris ? wd_q[EV_W-1:0] & {EV_W{ws_q[0]}} : '0;
    wire hib_req = wsel_ctl && en && wd_q[CTL_HIB] && ws_q[0];
    wire hib_go = (hib_req || hib_pend_q) && bc_q != BC_RUN;
    // abort enable written together with the request counts at once
    wire bat_en_now = wsel_ctl && ws_q[0] ? wd_q[CTL_BATEN] : ctl_q[CTL_BATEN];
    wire bat_abort = bat_en_now && ris_q[EV_LOWBAT];
    wire log_shown = {1'b0, log_rd_q} < log_cnt_q;                      // entry holds an event
    wire bc_start = wsel_ctl && en && wd_q[CTL_BATCHK] && ws_q[0] && bc_q == BC_IDLE;
    wire log_clr = wr_hit && awa_q == HPC_TPEVT;

    // read mux
    logic [31:0] rd_d;
    always_comb begin
        rd_d = '0;
        if (s_araddr[7:6] == 2'b01) begin
            rd_d = mem_q[ridx];
        end else begin
            unique case (s_araddr)
                HPC_CTL: begin
                    rd_d = ctl_q;
                    rd_d[CTL_BATCHK] = bc_q != BC_IDLE && bc_q != BC_DONE ? 1'b1 : 1'b0;
                    rd_d[CTL_ACTIVE] = active_q;
                    rd_d[CTL_HIB] = hib_pend_q;
                end
                HPC_RTC: rd_d = rtc_q;
                HPC_MATCH: rd_d = match_q;
                HPC_TRIM: rd_d = {16'h0000, trim_q};
                HPC_SS: rd_d = {17'h00000, ss_q};
                HPC_SSMATCH: rd_d = {17'h00000, ssm_q};
                HPC_CAL: rd_d = cal_q;
                HPC_CALM: rd_d = calm_q;
                HPC_WAKE: rd_d = {26'h0000000, wake_q};
                HPC_IM: rd_d = {26'h0000000, im_q};
                HPC_RIS: rd_d = {26'h0000000, ris_q};
                HPC_TPCTL: rd_d = tpctl_q;
                HPC_TPSTAT: rd_d = {25'h0000000, log_cnt_q, ext_osc_ok, |log_cnt_q,
                                    tpctl_q[0], ris_q[EV_TAMPER]};
                HPC_TPLOG: rd_d = log_shown ? log_rtc_q[log_rd_q] : 32'h00000000;
                HPC_TPEVT: rd_d = {27'h0000000, log_shown ? log_evt_q[log_rd_q] : 5'h00};
                default: rd_d = '0;
            endcase
        end
    end

    // axi write address and data capture, either order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
        end else begin
            s_awready <= !aw_q && !s_awready && s_awvalid;
            s_wready <= !w_q && !s_wready && s_wvalid;
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1;
                wd_q <= s_wdata;
                ws_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
            end
        end
    end

    // write response and read channel
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= 2'b00;
        end else begin
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp <= 2'b00;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            s_arready <= !s_arready && !s_rvalid && s_arvalid;
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rdata <= (en || s_araddr == HPC_CTL) ? rd_d : 32'h00000000;
                s_rresp <= 2'b00;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // control and configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= '0;
            trim_q <= TRIM_RST;
            match_q <= '0;
            ssm_q <= '0;
            calm_q <= '0;
            wake_q <= '0;
            im_q <= '0;
            tpctl_q <= '0;
        end else begin
            if (wr_hit) begin
                unique case (awa_q)
                    HPC_CTL: ctl_q <= merge(ctl_q, wd_q, ws_q) & 32'h00000017;
                    HPC_MATCH: match_q <= merge(match_q, wd_q, ws_q);
                    HPC_TRIM: trim_q <= trim_m[15:0];
                    HPC_SSMATCH: ssm_q <= ssm_m[SS_W-1:0];
                    HPC_CALM: calm_q <= merge(calm_q, wd_q, ws_q);
                    HPC_WAKE: wake_q <= wd_q[EV_W-1:0];
                    HPC_IM: im_q <= wd_q[EV_W-1:0];
                    HPC_TPCTL: tpctl_q <= merge(tpctl_q, wd_q, ws_q) & 32'h000001ff;
                    default: ;
                endcase
            end
        end
    end

    // counter, subseconds, calendar and prescaler
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rtc_q <= '0;
            ss_q <= '0;
            cal_q <= '0;
            tick_q <= '0;
            match_d1_q <= 1'b0;
        end else begin
            match_d1_q <= en && any_match;
            tick_q <= ss_tick ? 17'(signed'(trim_off)) & 17'h00000 : tick_q + 17'h00001;
            if (ss_tick) begin
                ss_q <= ss_q + 15'h0001;
            end
            if (sec_tick) begin
                tick_q <= 17'(int'(signed'(trim_off)) < 0 ? -int'(signed'(trim_off)) : 0);
                rtc_q <= rtc_q + 32'h00000001;
                cal_q[7:0] <= cal_q[7:0] == 8'h3b ? 8'h00 : cal_q[7:0] + 8'h01;
                if (cal_q[7:0] == 8'h3b) begin
                    cal_q[15:8] <= cal_q[15:8] == 8'h3b ? 8'h00 : cal_q[15:8] + 8'h01;
                    if (cal_q[15:8] == 8'h3b) begin
                        cal_q[23:16] <= cal_q[23:16] == 8'h17 ? 8'h00 : cal_q[23:16] + 8'h01;
                        if (cal_q[23:16] == 8'h17) begin
                            cal_q[31:24] <= cal_q[31:24] + 8'h01;
                        end
                    end
                end
            end
            if (!ctl_q[CTL_RUN]) begin
                tick_q <= '0;
            end
            if (wr_hit && awa_q == HPC_RTC) begin
                rtc_q <= merge(rtc_q, wd_q, ws_q);
                ss_q <= '0;
            end
            if (wr_hit && awa_q == HPC_CAL) begin
                cal_q <= merge(cal_q, wd_q, ws_q);
            end
        end
    end

    // status flags: set wins over a write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ris_q <= '0;
            wpin_q <= 1'b0;
            gpin_q <= 1'b0;
            rpin_q <= 1'b0;
            tin_q <= '0;
            osc_q <= 1'b0;
            wake_out <= 1'b0;
            tamper_evt <= 1'b0;
            low_battery_interrupt_flag <= 1'b0;
        end else begin
            ris_q <= (ris_q & ~ris_clr) | ev;
            wpin_q <= wake_pin;
            gpin_q <= gpio_wake;
            rpin_q <= rst_pin;
            tin_q <= tamper_in;
            osc_q <= ext_osc_ok;
            wake_out <= wake_ev && proc_power_off;
            tamper_evt <= tp_ev;
            low_battery_interrupt_flag <= |(((ris_q & ~ris_clr) | ev) & im_q) ||
                ev[EV_LOWBAT] || (ris_q[EV_LOWBAT] && !ris_clr[EV_LOWBAT]);
        end
    end

    // battery check, hibernate sequencing, active flag, oscillator recovery
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bc_q <= BC_IDLE;
            bc_cnt_q <= '0;
            hib_pend_q <= 1'b0;
            proc_power_off <= 1'b0;
            active_q <= 1'b0;
            caught_q <= 1'b0;
            osc_recover <= 1'b0;
        end else begin
            if (!caught_q) begin
                caught_q <= 1'b1;
                active_q <= por_warm;
            end else if (en) begin
                active_q <= 1'b1;
            end
            osc_recover <= wsel_ctl && en && wd_q[CTL_OSCREC] && ws_q[0] && !ext_osc_ok;
            unique case (bc_q)
                BC_IDLE: if (bc_start) begin
                    bc_q <= BC_RUN;
                    bc_cnt_q <= '0;
                end
                BC_RUN: begin
                    bc_cnt_q <= bc_cnt_q + 32'h00000001;
                    if (bc_cnt_q == 32'(BATCHK_CYC - 1)) begin
                        bc_q <= BC_DONE;
                    end
                end
                BC_DONE: bc_q <= BC_IDLE;
            endcase
            if (hib_req && bc_q == BC_RUN) begin
                hib_pend_q <= 1'b1;
            end
            if (hib_go) begin
                hib_pend_q <= 1'b0;
                if (!bat_abort) begin
                    proc_power_off <= 1'b1;
                end
            end
            if (wake_ev) begin
                proc_power_off <= 1'b0;
            end
        end
    end

    // battery memory, tamper clear, tamper log
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            log_cnt_q <= '0;
            log_rd_q <= '0;
        end else begin
            if (wmem && en) begin
                mem_q[widx] <= merge(mem_q[widx], wd_q, ws_q);
            end
            if (tp_ev && tpctl_q[6]) begin
                for (int i = 0; i < MEM_N; i++) begin
                    if (!tpctl_q[7] || i < MEM_N / 2) begin
                        mem_q[i] <= '0;
                    end
                end
            end
            if (wr_hit && awa_q == HPC_TPLOG) begin
                log_rd_q <= wd_q[1:0];
            end
            if (log_clr) begin
                log_cnt_q <= '0;
            end
            if (tp_ev && log_cnt_q < 3'(LOG_N)) begin
                log_rtc_q[log_cnt_q[1:0]] <= rtc_q;
                log_evt_q[log_cnt_q[1:0]] <= {osc_fail, tin_edge};
                log_cnt_q <= (log_clr ? 3'h0 : log_cnt_q) + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/hpc_top_assertions.sv ***
/* bus handshake and output timing checks for hpc_top.
   assumes one clock domain and synchronous active-high sys_rst. */
`timescale 1ns/10ps
`default_nettype none
module hpc_top_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic tamper_evt,
    input wire logic proc_power_off,
    input wire logic osc_recover
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_quiet; $fell(sys_rst) |-> !tamper_evt && !proc_power_off && !s_bvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("output busy after reset");
    property p_bhold; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer changed");
    property p_bsoon; s_wvalid && s_wready |-> ##[1:3] s_bvalid; endproperty
    a_bsoon: assert property (p_bsoon) else $error("write answer late");
    property p_rnext; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_rnext: assert property (p_rnext) else $error("read answer late");
    property p_bok; s_bvalid |-> s_bresp == 2'h0; endproperty
    a_bok: assert property (p_bok) else $error("write response not okay");
    property p_rok; s_rvalid |-> s_rresp == 2'h0; endproperty
    a_rok: assert property (p_rok) else $error("read response not okay");
    property p_awp; s_awready |=> !s_awready; endproperty
    a_awp: assert property (p_awp) else $error("address ready held");
    property p_osc; osc_recover |=> !osc_recover; endproperty
    a_osc: assert property (p_osc) else $error("recovery pulse too long");
endmodule
bind hpc_top hpc_top_chk u_chk (.clk, .sys_rst, .s_awready, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .tamper_evt, .proc_power_off, .osc_recover);
`default_nettype wire

// *** bench/hpc_sysctl_model.sv ***
/* system control side: counts tamper pulses and follows processor supply.
   assumes hpc_top outputs are synchronous to clk. */
`timescale 1ns/10ps
`default_nettype none
module hpc_sysctl_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tamper_evt,
    input wire logic proc_power_off,
    output logic [7:0] tp_cnt,
    output logic proc_on
);
    // tally tamper pulses, supply on unless power removal asked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tp_cnt <= 8'h00;
            proc_on <= 1'b1;
        end else begin
            tp_cnt <= tp_cnt + {7'h00, tamper_evt};
            proc_on <= !proc_power_off;
        end
    end
endmodule
`default_nettype wire

// *** bench/hpc_top_tb.sv ***
/* register level test of hpc_top over axi4-lite.
   assumes hpc_pkg offsets and a 20 mhz clock. */
`timescale 1ns/10ps
`default_nettype none
module hpc_top_tb;
    import hpc_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, ext_osc_ok = 1'b1, wake_pin = 1'b0;
    logic gpio_wake = 1'b0, rst_pin = 1'b0, bat_low_in = 1'b0, por_warm = 1'b1;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, tp_cnt;
    logic [31:0] s_wdata = 32'h0, s_rdata, rv, ss1;
    logic [3:0] s_wstrb = 4'hf;
    logic [TP_N-1:0] tamper_in = {TP_N{1'b0}};
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tamper_evt, proc_power_off;
    logic low_battery_interrupt_flag, wake_out, osc_recover, proc_on;
    logic [1:0] s_bresp, s_rresp;
    logic [7:0] ta [9] = '{HPC_RTC, HPC_MATCH, HPC_TRIM, HPC_SSMATCH, HPC_CALM, HPC_WAKE,
        HPC_IM, HPC_MEM, 8'h7c};
    logic [31:0] tv [9] = '{32'h5, 32'h12345678, 32'h7ff0, 32'h1234, 32'hffff0a05, 32'h4,
        32'h2, 32'ha5a55a5a, 32'h5a5aa5a5};
    int err_count = 0, n_checks = 0, i;
    always #25 clk = ~clk;
    hpc_top dut (.*);
    hpc_sysctl_model partner (.clk, .sys_rst, .tamper_evt, .proc_power_off, .tp_cnt, .proc_on);
    task stop_test;
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    // write: offer address and data together, release each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk); // keeps release and next raise of bready apart
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            n++;
        end while (!s_bvalid && n < 50);
        s_bready <= 1'b0;
        if (n == 50) chk("write_timeout", 32'h1, 32'h0);
    endtask
    // read: hold rready until the data comes
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge clk); // keeps release and next raise of rready apart
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
            n++;
        end while (!s_rvalid && n < 50);
        d = s_rdata;
        s_rready <= 1'b0;
        if (n == 50) chk("read_timeout", 32'h1, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(HPC_CTL, rv);
        chk("active", rv & 32'h80, 32'h80);
        wr(HPC_MATCH, 32'h1);
        rd(HPC_MATCH, rv);
        chk("before_enable", rv, 32'h0);
        wr(HPC_CTL, 32'h1); // module enable, no settling wait
        rd(HPC_TRIM, rv);
        chk("trim_reset", rv, {16'h0, TRIM_RST});
        rd(HPC_RIS, rv);
        chk("zero_match", rv & 32'h1, 32'h1);
        for (i = 0; i < 9; i++) begin
            wr(ta[i], tv[i]);
            rd(ta[i], rv);
            chk("reg_rw", rv, tv[i]);
        end
        rd(8'h3c, rv);
        chk("unmapped", rv, 32'h0);
        wr(HPC_CTL, 32'h3);
        rd(HPC_SS, ss1);
        repeat (2000) @(posedge clk);
        rd(HPC_SS, rv);
        chk("ss_moves", {31'h0, rv != ss1}, 32'h1);
        chk("ss_width", rv & 32'hffff8000, 32'h0);
        wr(HPC_CTL, 32'h1);
        rd(HPC_SS, ss1);
        repeat (2000) @(posedge clk);
        rd(HPC_SS, rv);
        chk("ss_stopped", rv, ss1);
        wr(HPC_TPCTL, 32'h3);
        rd(HPC_TPCTL, rv);
        chk("tamper_ctl", rv, 32'h3);
        tamper_in <= 4'h1;
        repeat (8) @(posedge clk);
        chk("tamper_pulses", tp_cnt, 8'h1);
        rd(HPC_TPEVT, rv);
        chk("tamper_logged", {31'h0, rv != 32'h0}, 32'h1);
        wr(HPC_TPEVT, 32'h0);
        rd(HPC_TPEVT, rv);
        chk("log_cleared", rv, 32'h0);
        wr(HPC_TPCTL, 32'h43);
        tamper_in <= 4'h0;
        repeat (4) @(posedge clk);
        rd(HPC_MEM, rv);
        chk("mem_wiped", rv, 32'h0);
        chk("tamper_pulses2", tp_cnt, 8'h2);
        ext_osc_ok <= 1'b0;
        wr(HPC_CTL, 32'h41);
        for (i = 0; i < 20 && !osc_recover; i++) @(posedge clk);
        chk("osc_recover", osc_recover, 1'b1);
        ext_osc_ok <= 1'b1;
        bat_low_in <= 1'b1;
        wr(HPC_CTL, 32'h21);
        rd(HPC_CTL, rv);
        chk("check_busy", rv & 32'h20, 32'h20);
        for (i = 0; i < 3000 && rv[CTL_BATCHK]; i++) rd(HPC_CTL, rv);
        chk("check_done", rv & 32'h20, 32'h0);
        rd(HPC_RIS, rv);
        chk("low_flag", rv & 32'h2, 32'h2);
        chk("low_signal", low_battery_interrupt_flag, 1'b1);
        wr(HPC_CTL, 32'h19);
        repeat (20) @(posedge clk);
        chk("abort_hib", proc_power_off, 1'b0);
        bat_low_in <= 1'b0;
        wr(HPC_RIS, 32'h3f); // handler clears all pending
        rd(HPC_RIS, rv);
        chk("ris_cleared", rv & 32'h2, 32'h0);
        wr(HPC_CTL, 32'h21);
        wr(HPC_CTL, 32'h9);
        for (i = 0; i < 3000 && !proc_power_off; i++) @(posedge clk);
        chk("held_off", {31'h0, i > 1500}, 32'h1);
        repeat (2) @(posedge clk);
        chk("power_removed", proc_on, 1'b0);
        wake_pin <= 1'b1;
        for (i = 0; i < 20 && !wake_out; i++) @(posedge clk);
        chk("wake", wake_out, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
